// *** dsp_feature_config_regs.v ***
// Four 8-bit feature configuration registers and their decoded controls.
// Assumes a synchronous control port: address, write strobe, data; read is combinational.
//
// What this block does
// - Two-bit clock source for activity logic
// - Two-bit external activity clock rate code
// - Bit 2 enables first-phase comparator detection
// - Limiter level source: max, ch1, ch0, average
// - Limiter gain applied: both, ch1, ch0, none
// - Bits 7..4 enable gain control ch1..4
// - Bits 3..0 enable compression ch1..4
// - Bit 7 switches power limiter on
// - Three-bit attenuation in 6 dB steps
// - Bit 3 selects analog-sample attenuation source
// - Recovery bit allows attenuation to decrease
`timescale 1ns/1ps
`include "feature_cfg_consts.vh"
module dsp_feature_config_regs (
    input wire sys_clk,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output wire reg_hit,
    output wire [1:0] activity_clock_source_sel,
    output wire [1:0] activity_external_clock_rate,
    output wire clk_src_int_osc,
    output wire clk_src_bit_clk,
    output wire clk_src_control_clock_input,
    output wire clk_src_custom,
    output wire first_phase_detect_enable,
    output wire [1:0] limiter_source_select,
    output wire [1:0] limiter_output_select,
    output wire limit_src_max,
    output wire limit_src_avg,
    output wire limit_src_ch1,
    output wire limit_src_ch0,
    output wire limit_apply_ch0,
    output wire limit_apply_ch1,
    output wire [3:0] gain_control_enable,
    output wire [3:0] compression_enable,
    output wire power_limiter_enable,
    output wire [2:0] power_limiter_attenuation,
    output wire [5:0] attenuation_db,
    output wire attenuation_from_analog_sample,
    output wire power_limiter_recover_enable
);
    // ************************************************************
    // Storage and write decode
    // ************************************************************
    wire [7:0] act_clk_r;
    wire [7:0] lim_route_r;
    wire [7:0] gain_comp_r;
    wire [7:0] pwr_lim_r;
    wire wr_act;
    wire wr_lim;
    wire wr_gain;
    wire wr_pwr;

    assign wr_act = reg_wr && (reg_addr == `ACT_CLK_CFG_ADDR);
    assign wr_lim = reg_wr && (reg_addr == `LIM_ROUTE_CFG_ADDR);
    assign wr_gain = reg_wr && (reg_addr == `GAIN_COMP_EN_ADDR);
    assign wr_pwr = reg_wr && (reg_addr == `PWR_LIM_CFG_ADDR);

    cfg_reg8 #(.RST_VAL(`ACT_CLK_CFG_RST), .WMASK(`ACT_CLK_CFG_WMASK)) u_act (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_en(wr_act),
        .wr_data(reg_wdata),
        .value_r(act_clk_r)
    );
    cfg_reg8 #(.RST_VAL(`LIM_ROUTE_CFG_RST), .WMASK(`LIM_ROUTE_CFG_WMASK)) u_lim (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_en(wr_lim),
        .wr_data(reg_wdata),
        .value_r(lim_route_r)
    );
    cfg_reg8 #(.RST_VAL(`GAIN_COMP_EN_RST), .WMASK(`GAIN_COMP_EN_WMASK)) u_gain (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_en(wr_gain),
        .wr_data(reg_wdata),
        .value_r(gain_comp_r)
    );
    cfg_reg8 #(.RST_VAL(`PWR_LIM_CFG_RST), .WMASK(`PWR_LIM_CFG_WMASK)) u_pwr (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_en(wr_pwr),
        .wr_data(reg_wdata),
        .value_r(pwr_lim_r)
    );

    // ************************************************************
    // Read path
    // ************************************************************
    // Unmapped offsets read zero so a probe never sees stale data
    assign reg_hit = (reg_addr == `ACT_CLK_CFG_ADDR) || (reg_addr == `LIM_ROUTE_CFG_ADDR) ||
                     (reg_addr == `GAIN_COMP_EN_ADDR) || (reg_addr == `PWR_LIM_CFG_ADDR);

    always @* begin
        case (reg_addr)
            `ACT_CLK_CFG_ADDR: reg_rdata = act_clk_r;
            `LIM_ROUTE_CFG_ADDR: reg_rdata = lim_route_r;
            `GAIN_COMP_EN_ADDR: reg_rdata = gain_comp_r;
            `PWR_LIM_CFG_ADDR: reg_rdata = pwr_lim_r;
            default: reg_rdata = 8'h00;
        endcase
    end

    // ************************************************************
    // Activity clocking
    // ************************************************************
    // clock source decode
    assign activity_clock_source_sel = act_clk_r[`ACT_CLK_SRC_HI:`ACT_CLK_SRC_LO];
    assign clk_src_int_osc = (activity_clock_source_sel == `CLK_SRC_INT_OSC);
    assign clk_src_bit_clk = (activity_clock_source_sel == `CLK_SRC_BIT_CLK);
    assign clk_src_control_clock_input = (activity_clock_source_sel == `CLK_SRC_CTRL_CLK);
    assign clk_src_custom = (activity_clock_source_sel == `CLK_SRC_CUSTOM);
    assign activity_external_clock_rate = act_clk_r[`ACT_EXT_RATE_HI:`ACT_EXT_RATE_LO];
    assign first_phase_detect_enable = act_clk_r[`ACT_PH1_EN_BIT];

    // ************************************************************
    // Limiter routing
    // ************************************************************
    // level source decode
    assign limiter_source_select = lim_route_r[`LIM_SRC_HI:`LIM_SRC_LO];
    assign limit_src_max = (limiter_source_select == `LIM_SRC_MAX);
    assign limit_src_ch1 = (limiter_source_select == `LIM_SRC_CH1);
    assign limit_src_ch0 = (limiter_source_select == `LIM_SRC_CH0);
    assign limit_src_avg = (limiter_source_select == `LIM_SRC_AVG);
    assign limiter_output_select = lim_route_r[`LIM_OUT_HI:`LIM_OUT_LO];
    assign limit_apply_ch1 = ~limiter_output_select[1];
    assign limit_apply_ch0 = ~limiter_output_select[0];

    // ************************************************************
    // Per-channel enables
    // ************************************************************
    // Output bit 0 is channel one, so bit order is reversed
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch = ch + 1) begin : g_ch
            assign gain_control_enable[ch] = gain_comp_r[`AGC_EN_HI - ch];
            assign compression_enable[ch] = gain_comp_r[`DRC_EN_HI - ch];
        end
    endgenerate

    // ************************************************************
    // Power limiter
    // ************************************************************
    // limiter on/off
    assign power_limiter_enable = pwr_lim_r[`PLIM_EN_BIT];
    assign power_limiter_attenuation = pwr_lim_r[`PLIM_ATTN_HI:`PLIM_ATTN_LO];
    assign attenuation_db = {3'h0, power_limiter_attenuation} * 6'd`ATTN_STEP_DB;
    assign attenuation_from_analog_sample = pwr_lim_r[`PLIM_SRC_BIT];
    assign power_limiter_recover_enable = pwr_lim_r[`PLIM_RECOV_BIT];
endmodule

// *** feature_cfg_consts.vh ***
// Offsets, field positions, reset values and masks of the feature configuration bank.
// Assumes an 8-bit control port addressed by register offset.
`ifndef FEATURE_CFG_CONSTS_VH
`define FEATURE_CFG_CONSTS_VH

// ************************************************************
// Register offsets
// ************************************************************
`define ACT_CLK_CFG_ADDR 8'h20
`define LIM_ROUTE_CFG_ADDR 8'h23
`define GAIN_COMP_EN_ADDR 8'h24
`define PWR_LIM_CFG_ADDR 8'h2B

// ************************************************************
// Reset values and writable masks
// ************************************************************
`define ACT_CLK_CFG_RST 8'h00
`define LIM_ROUTE_CFG_RST 8'h00
`define GAIN_COMP_EN_RST 8'h00
`define PWR_LIM_CFG_RST 8'h00
`define ACT_CLK_CFG_WMASK 8'hFC
`define LIM_ROUTE_CFG_WMASK 8'hF0
`define GAIN_COMP_EN_WMASK 8'hFF
`define PWR_LIM_CFG_WMASK 8'hFC

// ************************************************************
// Field positions
// ************************************************************
`define ACT_CLK_SRC_HI 7
`define ACT_CLK_SRC_LO 6
`define ACT_EXT_RATE_HI 5
`define ACT_EXT_RATE_LO 4
`define ACT_PH1_EN_BIT 2
`define LIM_SRC_HI 7
`define LIM_SRC_LO 6
`define LIM_OUT_HI 5
`define LIM_OUT_LO 4
`define AGC_EN_HI 7
`define AGC_EN_LO 4
`define DRC_EN_HI 3
`define DRC_EN_LO 0
`define PLIM_EN_BIT 7
`define PLIM_ATTN_HI 6
`define PLIM_ATTN_LO 4
`define PLIM_SRC_BIT 3
`define PLIM_RECOV_BIT 2

// ************************************************************
// Field codes
// ************************************************************
`define CLK_SRC_INT_OSC 2'h0
`define CLK_SRC_BIT_CLK 2'h1
`define CLK_SRC_CTRL_CLK 2'h2
`define CLK_SRC_CUSTOM 2'h3
`define EXT_RATE_24M576 2'h0
`define EXT_RATE_6M144 2'h1
`define EXT_RATE_12M288 2'h2
`define EXT_RATE_18M432 2'h3
`define LIM_SRC_MAX 2'h0
`define LIM_SRC_CH1 2'h1
`define LIM_SRC_CH0 2'h2
`define LIM_SRC_AVG 2'h3
`define ATTN_STEP_DB 6

`endif

// *** cfg_reg8.v ***
// One 8-bit configuration register with a writable-bit mask.
// Assumes a one-cycle write strobe synchronous to sys_clk.
`timescale 1ns/1ps
module cfg_reg8 #(
    parameter [7:0] RST_VAL = 8'h00,
    parameter [7:0] WMASK = 8'hFF
) (
    input wire sys_clk,
    input wire rst,
    input wire wr_en,
    input wire [7:0] wr_data,
    output reg [7:0] value_r
);
    // Read-only reserved bits hold zero whatever is written
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            value_r <= RST_VAL;
        end else if (wr_en) begin
            value_r <= wr_data & WMASK;
        end
    end
endmodule

// *** dsp_feature_config_regs_monitor.sv ***
// Checker for the feature configuration bank.
// Assumes single-cycle write strobes on sys_clk.
`timescale 1ns/1ps
module dsp_feature_config_regs_monitor (
    input wire sys_clk,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire reg_hit,
    input wire [1:0] activity_clock_source_sel,
    input wire clk_src_int_osc,
    input wire [1:0] limiter_output_select,
    input wire limit_apply_ch0,
    input wire [3:0] gain_control_enable,
    input wire [2:0] power_limiter_attenuation,
    input wire [5:0] attenuation_db,
    input wire attenuation_from_analog_sample,
    input wire power_limiter_recover_enable
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire plim_wr = reg_wr && reg_addr == 8'h2B;
    // ********
    // Assertions
    // ********
    chk_attn_db_scale: assert property (attenuation_db == power_limiter_attenuation * 6)
        else $error("attenuation_db is not six times the code");
    chk_unmapped_reads: assert property (!reg_hit |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_reserved_read_zero: assert property (reg_addr != 8'h24 |-> reg_rdata[1:0] == 2'h0
        && (reg_addr != 8'h23 || reg_rdata[3:2] == 2'h0)) else $error("reserved bits read nonzero");
    chk_attn_write: assert property (plim_wr |=> power_limiter_attenuation == $past(reg_wdata[6:4]))
        else $error("attenuation code not taken");
    chk_src_recover_bits: assert property (plim_wr |=> attenuation_from_analog_sample == $past(reg_wdata[3])
        && power_limiter_recover_enable == $past(reg_wdata[2])) else $error("source or recovery bit lost");
    chk_gain_bit_order: assert property (reg_wr && reg_addr == 8'h24 |=>
        gain_control_enable[0] == $past(reg_wdata[7]) && gain_control_enable[3] == $past(reg_wdata[4]))
        else $error("gain enable order wrong");
    chk_clk_src_decode: assert property (clk_src_int_osc == (activity_clock_source_sel == 2'h0))
        else $error("oscillator decode wrong");
    chk_apply_ch0_decode: assert property (limit_apply_ch0 == !limiter_output_select[0])
        else $error("channel zero apply decode wrong");
    chk_cfg_holds: assert property (!reg_wr |=> $stable(power_limiter_attenuation)
        && $stable(gain_control_enable)) else $error("config changed without write");
    cover property (plim_wr && reg_wdata[6:4] == 3'h7);
    cover property (reg_wr && !reg_hit);
    cover property (clk_src_int_osc ##1 !clk_src_int_osc);
endmodule
bind dsp_feature_config_regs dsp_feature_config_regs_monitor dsp_feature_config_regs_monitor_inst (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .activity_clock_source_sel(activity_clock_source_sel),
    .clk_src_int_osc(clk_src_int_osc), .limiter_output_select(limiter_output_select),
    .limit_apply_ch0(limit_apply_ch0), .gain_control_enable(gain_control_enable),
    .power_limiter_attenuation(power_limiter_attenuation), .attenuation_db(attenuation_db),
    .attenuation_from_analog_sample(attenuation_from_analog_sample),
    .power_limiter_recover_enable(power_limiter_recover_enable));

// *** dsp_feature_config_regs_test.sv ***
// Self-checking bench for the feature configuration bank.
// Assumes the monitor file is compiled ahead and binds itself.
`timescale 1ns/1ps
module dsp_feature_config_regs_test;
    reg sys_clk = 1'b0;
    reg rst = 1'b1;
    reg [7:0] reg_addr = 8'h00;
    reg reg_wr = 1'b0;
    reg [7:0] reg_wdata = 8'h00;
    wire [7:0] reg_rdata;
    wire reg_hit, clk_src_int_osc, clk_src_bit_clk, clk_src_control_clock_input, clk_src_custom;
    wire first_phase_detect_enable, limit_src_max, limit_src_avg, limit_src_ch1, limit_src_ch0;
    wire limit_apply_ch0, limit_apply_ch1, power_limiter_enable, attenuation_from_analog_sample;
    wire power_limiter_recover_enable;
    wire [1:0] activity_clock_source_sel, activity_external_clock_rate;
    wire [1:0] limiter_source_select, limiter_output_select;
    wire [3:0] gain_control_enable, compression_enable;
    wire [2:0] power_limiter_attenuation;
    wire [5:0] attenuation_db;
    integer num_errors = 0;
    integer num_checks = 0;
    integer i;
    dsp_feature_config_regs dsp_feature_config_regs_inst (.*);
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    // ********
    // Bus and compare tasks
    // ********
    task chk(input string what, input [7:0] exp, input [7:0] got);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("unexpected %0s: expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge sys_clk);
            #1 reg_addr = a;
            reg_wdata = d;
            reg_wr = 1'b1;
            @(posedge sys_clk);
            #1 reg_wr = 1'b0;
        end
    endtask
    // Read data is combinational, so no edge is needed
    task rd(input [7:0] a, input [7:0] exp);
        begin
            reg_addr = a;
            #1 chk("reg_rdata", exp, reg_rdata);
        end
    endtask
    // ********
    // Scenarios
    // ********
    task test_reset;
        begin
            rd(8'h20, 8'h00);
            rd(8'h23, 8'h00);
            rd(8'h24, 8'h00);
            rd(8'h2B, 8'h00);
            chk("reg_hit", 8'h01, reg_hit);
            rd(8'h21, 8'h00);
            chk("reg_hit", 8'h00, reg_hit);
            chk("oscillator", 1, clk_src_int_osc);
            chk("apply", 8'h07, {limit_apply_ch1, limit_apply_ch0, limit_src_max});
        end
    endtask
    task test_clock;
        for (i = 0; i < 4; i = i + 1) begin
            // Reserved bits are only ever written with zero
            wr(8'h20, {i[1:0], ~i[1:0], 1'b0, i[0], 2'b00});
            rd(8'h20, {i[1:0], ~i[1:0], 1'b0, i[0], 2'b00});
            chk("clk_sel", i[7:0], activity_clock_source_sel);
            chk("clk_src", 1 << i, {clk_src_custom, clk_src_control_clock_input,
                clk_src_bit_clk, clk_src_int_osc});
            chk("ext_rate", 8'h03 - i[7:0], activity_external_clock_rate);
            chk("phase1", i[0], first_phase_detect_enable);
        end
    endtask
    task test_limiter;
        for (i = 0; i < 16; i = i + 1) begin
            wr(8'h23, {i[3:0], 4'h0});
            rd(8'h23, {i[3:0], 4'h0});
            chk("lim_sel", i[3:2], limiter_source_select);
            chk("lim_out", i[1:0], limiter_output_select);
            chk("lim_src", 1 << i[3:2], {limit_src_avg, limit_src_ch0, limit_src_ch1,
                limit_src_max});
            chk("lim_apply", 8'h03 - i[1:0], {limit_apply_ch1, limit_apply_ch0});
        end
    endtask
    task test_plim;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                wr(8'h2B, {1'b1, i[2:0], i[0], ~i[0], 2'b00});
                rd(8'h2B, {1'b1, i[2:0], i[0], ~i[0], 2'b00});
                chk("attn_code", i[2:0], power_limiter_attenuation);
                chk("attn_db", i * 6, attenuation_db);
                chk("plim_bits", {1'b1, i[0], ~i[0]}, {power_limiter_enable,
                    attenuation_from_analog_sample, power_limiter_recover_enable});
            end
            wr(8'h2B, 8'h00);
            chk("plim_en", 0, power_limiter_enable);
        end
    endtask
    task test_gain;
        begin
            wr(8'h24, 8'hA5);
            wr(8'h25, 8'hFF);
            rd(8'h25, 8'h00);
            rd(8'h24, 8'hA5);
            chk("agc", 8'h05, gain_control_enable);
            chk("drc", 8'h0A, compression_enable);
            // Mid-run reset, moved 1 ns after the clock edge like the write stimulus
            @(posedge sys_clk);
            #1 rst = 1'b1;
            @(posedge sys_clk);
            #1 rst = 1'b0;
            rd(8'h24, 8'h00);
            chk("agc", 8'h00, gain_control_enable);
            chk("drc", 8'h00, compression_enable);
        end
    endtask
    task conclude;
        begin
            $display("checks %0d errors %0d", num_checks, num_errors);
            if (num_errors == 0 && num_checks > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        #1 rst = 1'b0;
        test_reset;
        test_clock;
        test_limiter;
        test_plim;
        test_gain;
        conclude;
    end
endmodule
